// [design/tbm_timer.sv]
// Timer channel with event counter and pulse period/width measurement, APB slave.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Event mode counts input pin edges or another timer's overflow.
// - Event mode active edge selectable: rising, falling or both.
// - Event mode counts down, reloads from reload register on underflow.
// - Programmed n gives one underflow per n plus one events.
// - Counting runs while start flag is one, halts when cleared.
// - Event mode raises interrupt request on each underflow.
// - Event mode timer read returns live counter value.
// - Event mode write while stopped loads reload register and counter.
// - Event mode write while running loads reload only; counter takes it later.
// - Measurement mode counts one of four prescaled clocks.
// - Measurement counts up; each effective edge captures, clears, continues.
// - Measurement edge raises interrupt, except first edge after start.
// - Measurement overflow raises interrupt and sets overflow flag.
// - Mode register write while started clears overflow flag.
// - Measurement mode timer read returns captured result.
// - Result is undefined before second effective edge after start.
// - Measurement mode ignores timer register writes.
// - Falling-to-falling period measurement captures on falling edges only.
// - Two-bit count source select picks div2, div8, div32, subclock div32.
module tbm_timer
#(
   parameter int TW = tbm_pkg::TIMER_W
)
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer_input_pin,
   input  wire logic        subclk_pin,
   input  wire logic        other_timer_ovf,
   output logic             int_req,
   output logic             underflow_out,
   output logic             overflow_flag
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [tbm_pkg::MODE_W-1:0] mode_reg;
   logic                       start_reg;
   logic                       start_prev_reg;
   logic [TW-1:0]              counter_reg;
   logic [TW-1:0]              reload_reg;
   logic                       edge_seen_reg;
   logic                       pin_meta_reg;
   logic                       pin_sync_reg;
   logic                       pin_prev_reg;
   logic                       clk_div_two;
   logic                       clk_div_eight;
   logic                       clk_div_thirtytwo;
   logic                       subclk_div_thirtytwo;

   tbm_pkg::tbm_mode_e         op_mode;
   logic [1:0]                 edge_sel;
   logic [1:0]                 cks_sel;
   logic                       src_other;
   logic                       is_event;
   logic                       is_meas;
   logic                       pin_rise;
   logic                       pin_fall;
   logic                       pin_edge;
   logic                       count_event;
   logic                       meas_edge;
   logic                       tick;
   logic                       run_event;
   logic                       run_meas;
   logic                       underflow;
   logic                       overflow;
   logic                       start_rise;
   logic                       addr_hit;
   logic                       setup_rd;
   logic                       acc_wr;
   logic                       wr_mode;
   logic                       wr_start;
   logic                       wr_timer;
   logic [31:0]                rd_value;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   assign op_mode   = tbm_pkg::tbm_mode_e'(mode_reg[tbm_pkg::MODE_SEL_LSB +: 2]);
   assign edge_sel  = mode_reg[tbm_pkg::EDGE_SEL_LSB +: 2];
   assign cks_sel   = mode_reg[tbm_pkg::CKS_SEL_LSB +: 2];
   assign src_other = mode_reg[tbm_pkg::SRC_SEL_BIT];
   assign is_event  = op_mode == tbm_pkg::TBM_MODE_EVENT;
   assign is_meas   = op_mode == tbm_pkg::TBM_MODE_MEASURE;
   assign run_event = is_event && start_reg;
   assign run_meas  = is_meas && start_reg;
   assign start_rise = start_reg && !start_prev_reg;

   // ----------------------------------------------------------------
   // Input pin synchroniser and edge detection
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end
      else
      begin
         pin_meta_reg <= timer_input_pin;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   assign pin_rise = pin_sync_reg && !pin_prev_reg;
   assign pin_fall = !pin_sync_reg && pin_prev_reg;
   assign pin_edge = pin_rise || pin_fall;

   // ----------------------------------------------------------------
   // Count source selection
   // ----------------------------------------------------------------
   tbm_prescaler u_prescaler
   (
      .clock                (clock),
      .rst_n                (rst_n),
      .subclk_pin           (subclk_pin),
      .clk_div_two          (clk_div_two),
      .clk_div_eight        (clk_div_eight),
      .clk_div_thirtytwo    (clk_div_thirtytwo),
      .subclk_div_thirtytwo (subclk_div_thirtytwo)
   );

   always_comb
   begin
      count_event = 1'b0;
      if (src_other)
      begin
         count_event = other_timer_ovf;
      end
      else
      begin
         case (edge_sel)
            tbm_pkg::EDGE_FALL: count_event = pin_fall;
            tbm_pkg::EDGE_RISE: count_event = pin_rise;
            tbm_pkg::EDGE_BOTH: count_event = pin_edge;
            default:            count_event = 1'b0;
         endcase
      end
   end

   always_comb
   begin
      case (edge_sel)
         tbm_pkg::MEAS_PER_FALL: meas_edge = pin_fall;
         tbm_pkg::MEAS_PER_RISE: meas_edge = pin_rise;
         tbm_pkg::MEAS_WIDTH:    meas_edge = pin_edge;
         default:                meas_edge = 1'b0;
      endcase
   end

   always_comb
   begin
      case (cks_sel)
         tbm_pkg::CKS_DIV2:  tick = clk_div_two;
         tbm_pkg::CKS_DIV8:  tick = clk_div_eight;
         tbm_pkg::CKS_DIV32: tick = clk_div_thirtytwo;
         default:            tick = subclk_div_thirtytwo;
      endcase
   end

   // Edge takes precedence over a tick in the same cycle, so no overflow then
   assign underflow = run_event && count_event && (counter_reg == '0);
   assign overflow  = run_meas && !meas_edge && tick
                      && (counter_reg == tbm_pkg::CNT_MAX[TW-1:0]);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   always_comb
   begin
      if (paddr == tbm_pkg::ADDR_MODE)
      begin
         addr_hit = 1'b1;
         rd_value = {{(32-tbm_pkg::MODE_W){1'b0}}, mode_reg};
      end
      else if (paddr == tbm_pkg::ADDR_START)
      begin
         addr_hit = 1'b1;
         rd_value = {31'h00000000, start_reg};
      end
      else if (paddr == tbm_pkg::ADDR_TIMER)
      begin
         addr_hit = 1'b1;
         // Measurement result stays undefined until two edges have been seen
         if (is_meas)
            rd_value = {{(32-TW){1'b0}}, reload_reg};
         else
            rd_value = {{(32-TW){1'b0}}, counter_reg};
      end
      else if (paddr == tbm_pkg::ADDR_STATUS)
      begin
         addr_hit = 1'b1;
         rd_value = {30'h00000000, edge_seen_reg, overflow_flag};
      end
      else
      begin
         addr_hit = 1'b0;
         rd_value = 32'h00000000;
      end
   end

   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !addr_hit;
   assign setup_rd = psel && !penable && !pwrite;
   assign acc_wr   = psel && penable && pwrite && addr_hit;
   assign wr_mode  = acc_wr && (paddr == tbm_pkg::ADDR_MODE);
   assign wr_start = acc_wr && (paddr == tbm_pkg::ADDR_START);
   assign wr_timer = acc_wr && (paddr == tbm_pkg::ADDR_TIMER);

   // Read data is latched in the setup cycle so it is a flop during access
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h00000000;
      else if (setup_rd)
         prdata <= rd_value;
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         mode_reg <= tbm_pkg::MODE_RST;
      else if (wr_mode)
         mode_reg <= pwdata[tbm_pkg::MODE_W-1:0];
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         start_reg      <= 1'b0;
         start_prev_reg <= 1'b0;
      end
      else
      begin
         start_prev_reg <= start_reg;
         if (wr_start)
            start_reg <= pwdata[0];
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         counter_reg <= tbm_pkg::CNT_RST[TW-1:0];
      else if (wr_timer && is_event && !start_reg)
         counter_reg <= pwdata[TW-1:0];
      else if (run_event && count_event)
      begin
         if (underflow)
            counter_reg <= reload_reg;
         else
            counter_reg <= counter_reg - 1'b1;
      end
      else if (run_meas)
      begin
         if (meas_edge)
            counter_reg <= tbm_pkg::CNT_RST[TW-1:0];
         else if (tick)
            counter_reg <= counter_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Reload register
   // ----------------------------------------------------------------
   // Measurement mode drops timer writes entirely
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         reload_reg <= tbm_pkg::CNT_RST[TW-1:0];
      else if (wr_timer && is_event)
         reload_reg <= pwdata[TW-1:0];
      else if (run_meas && meas_edge)
         reload_reg <= counter_reg;
   end

   // ----------------------------------------------------------------
   // First edge tracking
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         edge_seen_reg <= 1'b0;
      else if (!start_reg || start_rise)
         edge_seen_reg <= 1'b0;
      else if (run_meas && meas_edge)
         edge_seen_reg <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Overflow flag: hardware set wins over the software clear
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         overflow_flag <= 1'b0;
      else if (overflow)
         overflow_flag <= 1'b1;
      else if (wr_mode && start_reg)
         overflow_flag <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Interrupt request and chaining pulses
   // ----------------------------------------------------------------
   // The first edge after start is skipped: nothing was measured before it
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_req       <= 1'b0;
         underflow_out <= 1'b0;
      end
      else
      begin
         int_req       <= underflow
                          || (run_meas && meas_edge && edge_seen_reg && !start_rise)
                          || overflow;
         underflow_out <= underflow;
      end
   end

endmodule

`default_nettype wire

// [common/tbm_pkg.sv]
// Shared constants for the timer channel.
package tbm_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] ADDR_MODE     = 12'h000;
   localparam logic [11:0] ADDR_START    = 12'h004;
   localparam logic [11:0] ADDR_TIMER    = 12'h008;
   localparam logic [11:0] ADDR_STATUS   = 12'h00C;

   // ----------------------------------------------------------------
   // Mode register layout
   // ----------------------------------------------------------------
   localparam int          MODE_W        = 8;
   localparam int          MODE_SEL_LSB  = 0;
   localparam int          EDGE_SEL_LSB  = 2;
   localparam int          SRC_SEL_BIT   = 4;
   localparam int          CKS_SEL_LSB   = 6;
   localparam logic [7:0]  MODE_RST      = 8'h00;

   typedef enum logic [1:0] {
      TBM_MODE_IDLE,
      TBM_MODE_EVENT,
      TBM_MODE_MEASURE,
      TBM_MODE_RSVD
   } tbm_mode_e;

   // Event counter active edge
   localparam logic [1:0]  EDGE_FALL     = 2'h0;
   localparam logic [1:0]  EDGE_RISE     = 2'h1;
   localparam logic [1:0]  EDGE_BOTH     = 2'h2;

   // Measurement kind
   localparam logic [1:0]  MEAS_PER_FALL = 2'h0;
   localparam logic [1:0]  MEAS_PER_RISE = 2'h1;
   localparam logic [1:0]  MEAS_WIDTH    = 2'h2;

   // Count source select
   localparam logic [1:0]  CKS_DIV2      = 2'h0;
   localparam logic [1:0]  CKS_DIV8      = 2'h1;
   localparam logic [1:0]  CKS_DIV32     = 2'h2;
   localparam logic [1:0]  CKS_SUB32     = 2'h3;

   // ----------------------------------------------------------------
   // Prescaler and counter constants
   // ----------------------------------------------------------------
   localparam int          PRE_W         = 5;
   localparam logic [4:0]  PRE_MASK2     = 5'h01;
   localparam logic [4:0]  PRE_MASK8     = 5'h07;
   localparam logic [4:0]  PRE_MASK32    = 5'h1F;
   localparam int          TIMER_W       = 16;
   localparam logic [15:0] CNT_RST       = 16'h0000;
   localparam logic [15:0] CNT_MAX       = 16'hFFFF;

endpackage

// [design/tbm_prescaler.sv]
// Prescaler producing the four count source pulses.
`timescale 1ns/1ps
`default_nettype none

module tbm_prescaler
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic subclk_pin,
   output logic      clk_div_two,
   output logic      clk_div_eight,
   output logic      clk_div_thirtytwo,
   output logic      subclk_div_thirtytwo
);

   logic [tbm_pkg::PRE_W-1:0] main_cnt_reg;
   logic [tbm_pkg::PRE_W-1:0] sub_cnt_reg;
   logic                      sub_meta_reg;
   logic                      sub_sync_reg;
   logic                      sub_prev_reg;

   // ----------------------------------------------------------------
   // Main clock division
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         main_cnt_reg      <= '0;
         clk_div_two       <= 1'b0;
         clk_div_eight     <= 1'b0;
         clk_div_thirtytwo <= 1'b0;
      end
      else
      begin
         main_cnt_reg      <= main_cnt_reg + 1'b1;
         clk_div_two       <= (main_cnt_reg & tbm_pkg::PRE_MASK2) == tbm_pkg::PRE_MASK2;
         clk_div_eight     <= (main_cnt_reg & tbm_pkg::PRE_MASK8) == tbm_pkg::PRE_MASK8;
         clk_div_thirtytwo <= main_cnt_reg == tbm_pkg::PRE_MASK32;
      end
   end

   // ----------------------------------------------------------------
   // Subclock division; the subclock is asynchronous, so sync first
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sub_meta_reg         <= 1'b0;
         sub_sync_reg         <= 1'b0;
         sub_prev_reg         <= 1'b0;
         sub_cnt_reg          <= '0;
         subclk_div_thirtytwo <= 1'b0;
      end
      else
      begin
         sub_meta_reg         <= subclk_pin;
         sub_sync_reg         <= sub_meta_reg;
         sub_prev_reg         <= sub_sync_reg;
         subclk_div_thirtytwo <= 1'b0;
         if (sub_sync_reg && !sub_prev_reg)
         begin
            sub_cnt_reg          <= sub_cnt_reg + 1'b1;
            subclk_div_thirtytwo <= sub_cnt_reg == tbm_pkg::PRE_MASK32;
         end
      end
   end

endmodule

`default_nettype wire

// [bench/tbm_timer_monitor.sv]
// Port checker for the timer channel, bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module tbm_timer_monitor
#(
   parameter int TW = 16
)
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timer_input_pin,
   input wire logic        subclk_pin,
   input wire logic        other_timer_ovf,
   input wire logic        int_req,
   input wire logic        underflow_out,
   input wire logic        overflow_flag
);
   logic       start_sh, wr_acc, mode_wr, unmapped;
   logic [1:0] mode_sh, stop_cnt;
   assign wr_acc = psel && penable && pwrite;
   assign mode_wr = wr_acc && paddr == tbm_pkg::ADDR_MODE;
   assign unmapped = !(paddr inside {tbm_pkg::ADDR_MODE, tbm_pkg::ADDR_START,
                                     tbm_pkg::ADDR_TIMER, tbm_pkg::ADDR_STATUS});
   // ----------------------------------------------------------------
   // Shadows of software state
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         start_sh <= 1'b0;
      else if (wr_acc && paddr == tbm_pkg::ADDR_START)
         start_sh <= pwdata[0];
   end
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         mode_sh <= 2'h0;
      else if (mode_wr)
         mode_sh <= pwdata[1:0];
   end
   // Margin of three cycles covers the input pipeline after a stop
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         stop_cnt <= 2'h0;
      else if (start_sh)
         stop_cnt <= 2'h0;
      else if (stop_cnt != 2'h3)
         stop_cnt <= stop_cnt + 2'h1;
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_uf_irq;
      underflow_out |-> int_req;
   endproperty
   a_uf_irq: assert property (p_uf_irq)
      else $error("underflow, no irq");
   property p_uf_mode;
      mode_sh != 2'h1 && $past(mode_sh) != 2'h1 |-> !underflow_out;
   endproperty
   a_uf_mode: assert property (p_uf_mode)
      else $error("underflow outside event mode");
   property p_ovf_irq;
      $rose(overflow_flag) |-> int_req;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq)
      else $error("overflow flag, no irq");
   property p_ovf_mode;
      $rose(overflow_flag) |-> mode_sh == 2'h2;
   endproperty
   a_ovf_mode: assert property (p_ovf_mode)
      else $error("overflow flag outside measure");
   property p_ovf_clr;
      mode_wr && start_sh |=> !overflow_flag || int_req;
   endproperty
   a_ovf_clr: assert property (p_ovf_clr)
      else $error("overflow flag not cleared");
   property p_ovf_hold;
      overflow_flag && !(mode_wr && start_sh) |=> overflow_flag;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold)
      else $error("overflow flag lost");
   property p_stop;
      stop_cnt == 2'h3 |-> !int_req && !underflow_out;
   endproperty
   a_stop: assert property (p_stop)
      else $error("activity while stopped");
   property p_err;
      psel && penable |-> pslverr == unmapped;
   endproperty
   a_err: assert property (p_err)
      else $error("pslverr mismatch");
   property p_err_data;
      psel && penable && !pwrite && unmapped |-> prdata == 32'h0 && pready;
   endproperty
   a_err_data: assert property (p_err_data)
      else $error("unmapped read data");
   c_uf: cover property (underflow_out);
   c_ovf: cover property ($rose(overflow_flag));
   c_err: cover property (pslverr);
   c_meas_irq: cover property (int_req && mode_sh == 2'h2);
endmodule
bind tbm_timer tbm_timer_monitor #(.TW(TW)) u_mon (.clock(clock), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_input_pin(timer_input_pin),
   .subclk_pin(subclk_pin), .other_timer_ovf(other_timer_ovf), .int_req(int_req),
   .underflow_out(underflow_out), .overflow_flag(overflow_flag));
`default_nettype wire

// [bench/tbm_pulse_src.sv]
// External pulse source and free-running subclock.
`timescale 1ns/1ps
`default_nettype none
module tbm_pulse_src
(
   input  wire logic clock,
   output var logic  timer_input_pin,
   output var logic  subclk_pin
);
   int ph;
   initial
   begin
      timer_input_pin = 1'b0;
      subclk_pin = 1'b0;
      ph = 0;
   end
   // Subclock runs free at a quarter of the system clock
   always @(posedge clock)
   begin
      ph <= ph + 1;
      subclk_pin <= ph[1];
   end
   // Called just after a rising edge; the pin keeps its level between pulses
   task automatic pulse(input int hi, input int lo);
      timer_input_pin <= 1'b1;
      repeat (hi) @(posedge clock);
      timer_input_pin <= 1'b0;
      repeat (lo) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// [bench/timer_b_event_and_pulse_measure_bench.sv]
// Self-checking testbench for the timer channel.
`timescale 1ns/1ps
`default_nettype none
module timer_b_event_and_pulse_measure_bench;
   logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, re, overflow_flag;
   logic        timer_input_pin, subclk_pin, other_timer_ovf, int_req, underflow_out;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   int          n_mismatch, total_checks, n_irq, n_uf, seed, m_cnt, m_rel, m_irq;
   localparam logic [11:0] A_MD = tbm_pkg::ADDR_MODE, A_ST = tbm_pkg::ADDR_START;
   localparam logic [11:0] A_TM = tbm_pkg::ADDR_TIMER, A_SR = tbm_pkg::ADDR_STATUS;
   int          kt[4] = '{2, 8, 32, 128};
   tbm_timer DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_input_pin(timer_input_pin), .subclk_pin(subclk_pin),
      .other_timer_ovf(other_timer_ovf), .int_req(int_req), .underflow_out(underflow_out),
      .overflow_flag(overflow_flag));
   tbm_pulse_src SRC (.clock(clock), .timer_input_pin(timer_input_pin),
      .subclk_pin(subclk_pin));
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Pulses are counted away from the launching edge
   always @(negedge clock)
   begin
      if (int_req === 1'b1)
         n_irq++;
      if (underflow_out === 1'b1)
         n_uf++;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic ev();
      if (m_cnt == 0)
      begin
         m_cnt = m_rel;
         m_irq++;
      end
      else
         m_cnt--;
   endtask
   // Low time includes the input pipeline delay before the next read
   task automatic pin(input logic [1:0] es, input bit model);
      SRC.pulse(4 + ($random(seed) & 3), 6 + ($random(seed) & 3));
      if (model && es != tbm_pkg::EDGE_FALL)
         ev();
      if (model && es != tbm_pkg::EDGE_RISE)
         ev();
   endtask
   task automatic ev_test(input logic [1:0] es);
      int i0, u0;
      m_rel = $random(seed) & 3;
      m_cnt = m_rel;
      m_irq = 0;
      wr(A_MD, {28'h0, es, 2'h1});
      wr(A_TM, 32'(m_cnt));
      rd(A_TM);
      chk("stopped load", rv, 32'(m_cnt));
      i0 = n_irq;
      u0 = n_uf;
      wr(A_ST, 32'h1);
      repeat (5) pin(es, 1'b1);
      rd(A_TM);
      chk("event count", rv, 32'(m_cnt));
      m_rel = 5;
      wr(A_TM, 32'h5);
      rd(A_TM);
      chk("running write", rv, 32'(m_cnt));
      repeat (6) pin(es, 1'b1);
      rd(A_TM);
      chk("new reload", rv, 32'(m_cnt));
      chk("irq count", 32'(n_irq - i0), 32'(m_irq));
      chk("underflow count", 32'(n_uf - u0), 32'(m_irq));
      wr(A_ST, 32'h0);
      repeat (2) pin(es, 1'b0);
      rd(A_TM);
      chk("stopped count", rv, 32'(m_cnt));
   endtask
   task automatic meas(input logic [1:0] kind, input logic [1:0] cks, input int half,
                       input int k);
      int          i0;
      int          e;
      logic [31:0] v;
      e = (kind == tbm_pkg::MEAS_WIDTH ? half : 2 * half) / k;
      wr(A_MD, {24'h0, cks, 2'h0, kind, 2'h2});
      i0 = n_irq;
      wr(A_ST, 32'h1);
      repeat (3) SRC.pulse(half, half);
      repeat (8) @(posedge clock);
      rd(A_TM);
      v = rv;
      chk("capture", 32'(v == e || v == e - 1), 32'h1);
      chk("edge irqs", 32'(n_irq - i0), kind == tbm_pkg::MEAS_WIDTH ? 32'h5 : 32'h2);
      rd(A_SR);
      chk("edge seen", rv, 32'h2);
      wr(A_TM, 32'h1234);
      rd(A_TM);
      chk("write ignored", rv, v);
      wr(A_ST, 32'h0);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      int i0;
      seed = 68;
      n_mismatch = 0;
      total_checks = 0;
      n_irq = 0;
      n_uf = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      other_timer_ovf = 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(A_MD);
      chk("mode reset", rv, 32'h0);
      rd(A_SR);
      chk("status reset", rv, 32'h0);
      rd(12'h010);
      chk("unmapped err", {31'h0, re}, 32'h1);
      chk("unmapped data", rv, 32'h0);
      for (int i = 0; i < 3; i++)
         ev_test(2'(i));
      m_cnt = 1;
      m_rel = 1;
      wr(A_MD, 32'h11);
      wr(A_TM, 32'h1);
      wr(A_ST, 32'h1);
      repeat (4)
      begin
         other_timer_ovf <= 1'b1;
         @(posedge clock);
         other_timer_ovf <= 1'b0;
         repeat (3) @(posedge clock);
         ev();
      end
      pin(2'h0, 1'b0);
      rd(A_TM);
      chk("chained count", rv, 32'(m_cnt));
      wr(A_ST, 32'h0);
      wr(A_MD, 32'h1);
      wr(A_TM, 32'hFFFE);
      wr(A_MD, 32'h2);
      i0 = n_irq;
      wr(A_ST, 32'h1);
      repeat (20) @(posedge clock);
      rd(A_SR);
      chk("overflow flag", rv, 32'h1);
      chk("overflow irq", 32'(n_irq - i0), 32'h1);
      wr(A_ST, 32'h0);
      wr(A_MD, 32'h2);
      rd(A_SR);
      chk("flag kept", rv, 32'h1);
      wr(A_ST, 32'h1);
      wr(A_MD, 32'h2);
      rd(A_SR);
      chk("flag cleared", rv, 32'h0);
      wr(A_ST, 32'h0);
      for (int c = 0; c < 4; c++)
         meas(tbm_pkg::MEAS_PER_FALL, 2'(c), 256, kt[c]);
      for (int j = 0; j < 3; j++)
         meas(2'(j), tbm_pkg::CKS_DIV8, 64, 8);
      stop_test();
   end
   initial
   begin
      #400000;
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
